// ===== hdl/pio_io_pulse_gen.sv
// Processor end of the bussed programmed-transfer I/O interface: slow cycle
// control, three-slot pulse generator, select code drive, accumulator and
// skip sampling. Assumes bus inputs are synchronous and active low.
//
// How it works
// - Opcode 6 in the top three bits marks an I/O transfer; slow cycle.
// - Each I/O transfer takes one expanded cycle of about 4.25 us.
// - Slow cycle with fourth timing pulse starts I/O and sets pause.
// - Three slots; bits 11, 10, 9 gate first, second, third pulse.
// - Pulse only if its bit is one; all slots always elapse.
// - A strobe follows the end of each slot's pulse; the input lines are sampled during the pulse.
// - After the third slot pause clears and normal timing resumes.
// - Every I/O transfer uses the slow cycle, no shortcuts.
// - True and complement of instruction bits 3 to 8 drive select code.
// - All transfers pass the 12-bit accumulator, up to twelve bits wide.
// - Skip bus low at pulse end advances program counter by one.
// - Input bus low sets accumulator bits; OR unless clear line asserted.
`timescale 1ns/1ns
module pio_io_pulse_gen #(
	parameter int SLOT_CLKS  = pio_pkg::SLOT_CLKS,
	parameter int PULSE_CLKS = pio_pkg::PULSE_CLKS
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// Processor core side
	input  wire logic [11:0] memory_buffer_register,
	input  wire logic        instr_valid,
	input  wire logic        fourth_timing_pulse,
	input  wire logic        acc_load,
	input  wire logic [11:0] acc_load_data,
	output logic             io_pause,
	output logic             io_strobe,
	output logic             io_done,
	output logic             pc_skip,
	output logic [11:0]      working_accumulator,
	// I/O bus
	output logic             processor_pulse_first,
	output logic             processor_pulse_second,
	output logic             processor_pulse_third,
	output logic [5:0]       select_code_true,
	output logic [5:0]       select_code_comp,
	output logic [11:0]      buffered_accumulator_lines,
	input  wire logic [11:0] acc_in_bus_n,
	input  wire logic        accumulator_clear_line_low,
	input  wire logic        skip_bus_n
);

	pio_pkg::pio_state_t state_q, state_d;
	logic [11:0] instr_q, instr_d;
	logic [11:0] acc_q, acc_d;
	logic [2:0]  pulse_q, pulse_d;
	logic        pause_q, pause_d;
	logic        strobe_q, strobe_d;
	logic        done_q, done_d;
	logic        skip_seen_q, skip_seen_d;
	logic        skip_q, skip_d;
	logic        slow_cycle;
	logic        io_start;
	logic        win;
	logic        last;
	logic        slot_end;
	logic [2:0]  slot_sel;

	// No shorter path for internal functions: every opcode 6 is slow
	assign slow_cycle = instr_valid && (memory_buffer_register
		[pio_pkg::OPC_MSB:pio_pkg::OPC_LSB] == pio_pkg::OPC_IOT);
	assign io_start = slow_cycle && fourth_timing_pulse
		&& (state_q == pio_pkg::ST_IDLE);

	pio_slot_timer #(
		.SLOT_CLKS  (SLOT_CLKS),
		.PULSE_CLKS (PULSE_CLKS)
	) u_timer (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.run      (state_q != pio_pkg::ST_IDLE),
		.win      (win),
		.last     (last),
		.slot_end (slot_end)
	);

	assign slot_sel = {state_q == pio_pkg::ST_SLOT3,
		state_q == pio_pkg::ST_SLOT2, state_q == pio_pkg::ST_SLOT1};

	// Sequencer and pause
	always_comb begin
		state_d = state_q;
		instr_d = instr_q;
		pause_d = pause_q;
		done_d  = 1'b0;
		unique case (state_q)
			pio_pkg::ST_IDLE: begin
				if (io_start) begin
					instr_d = memory_buffer_register;
					pause_d = 1'b1;
					state_d = pio_pkg::ST_SLOT1;
				end
			end
			pio_pkg::ST_SLOT1: begin
				if (slot_end) state_d = pio_pkg::ST_SLOT2;
			end
			pio_pkg::ST_SLOT2: begin
				if (slot_end) state_d = pio_pkg::ST_SLOT3;
			end
			pio_pkg::ST_SLOT3: begin
				if (slot_end) begin
					pause_d = 1'b0;
					done_d  = 1'b1;
					state_d = pio_pkg::ST_IDLE;
				end
			end
			default: state_d = pio_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= pio_pkg::ST_IDLE;
			instr_q <= pio_pkg::WORD_RST;
			pause_q <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			instr_q <= instr_d;
			pause_q <= pause_d;
			done_q  <= done_d;
		end
	end

	// Pulses, strobe, skip and accumulator
	always_comb begin
		// Slot k pulse gated by vector bit k, i.e. instruction bit 11-k
		pulse_d     = slot_sel & instr_q[pio_pkg::GATE_W-1:0]
			& {pio_pkg::GATE_W{win}};
		strobe_d    = last;
		skip_seen_d = skip_seen_q;
		skip_d      = 1'b0;
		acc_d       = acc_q;
		if (io_start) begin
			skip_seen_d = 1'b0;
		end
		// Sampled on the pulse's last cycle, while the device still drives it
		if (last && (|pulse_q) && !skip_bus_n) begin
			skip_seen_d = 1'b1;
		end
		if (done_d) begin
			skip_d = skip_seen_d;
		end
		if (acc_load) begin
			acc_d = acc_load_data;
		end else if (|pulse_q) begin
			// Clear and set in one pulse leave only the incoming bits
			acc_d = (accumulator_clear_line_low ? acc_q : '0)
				| ~acc_in_bus_n;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pulse_q     <= '0;
			strobe_q    <= 1'b0;
			skip_seen_q <= 1'b0;
			skip_q      <= 1'b0;
			acc_q       <= pio_pkg::WORD_RST;
		end else begin
			pulse_q     <= pulse_d;
			strobe_q    <= strobe_d;
			skip_seen_q <= skip_seen_d;
			skip_q      <= skip_d;
			acc_q       <= acc_d;
		end
	end

	assign io_pause                   = pause_q;
	assign io_strobe                  = strobe_q;
	assign io_done                    = done_q;
	assign pc_skip                    = skip_q;
	assign working_accumulator        = acc_q;
	assign buffered_accumulator_lines = acc_q;
	assign processor_pulse_first      = pulse_q[0];
	assign processor_pulse_second     = pulse_q[1];
	assign processor_pulse_third      = pulse_q[2];
	// Select code held from the latched word for the whole cycle
	assign select_code_true =
		instr_q[pio_pkg::SEL_MSB:pio_pkg::SEL_LSB];
	assign select_code_comp =
		~instr_q[pio_pkg::SEL_MSB:pio_pkg::SEL_LSB];

	// Checks
	logic [pio_pkg::CNT_W:0] pause_cnt_q;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pause_cnt_q <= '0;
		end else begin
			pause_cnt_q <= pause_q ? pause_cnt_q + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	AST_START_PAUSE: assert property (
		slow_cycle && fourth_timing_pulse && !io_pause |=> io_pause)
		else $error("slow cycle start did not set pause");
	AST_NO_START: assert property (
		!io_pause && !(slow_cycle && fourth_timing_pulse) |=> !io_pause)
		else $error("pause set without an I/O start");
	AST_PAUSE_LEN: assert property (
		$fell(io_pause) |-> pause_cnt_q == 3 * SLOT_CLKS
		&& io_done)
		else $error("expanded cycle length wrong");
	AST_FIRST_GATE: assert property (
		processor_pulse_first |-> instr_q[0]
		&& $past(state_q) == pio_pkg::ST_SLOT1)
		else $error("first pulse outside its slot or bit");
	AST_THIRD_GATE: assert property (
		state_q == pio_pkg::ST_SLOT3 && instr_q[2] && win
		|=> processor_pulse_third)
		else $error("third pulse missing");
	AST_STROBE: assert property (
		$fell(processor_pulse_second) |-> io_strobe ##1 !io_strobe)
		else $error("strobe did not follow pulse end");
	AST_NO_OVERLAP: assert property (
		$onehot0({processor_pulse_first, processor_pulse_second,
		processor_pulse_third}))
		else $error("processor pulses overlap");
	AST_SELECT: assert property (
		io_pause |-> select_code_comp == ~select_code_true
		&& (!$past(io_pause) || $stable(select_code_true)))
		else $error("select code unstable or not complementary");
	AST_SKIP: assert property (
		io_done || pc_skip |-> io_done && pc_skip == skip_seen_q
		##1 !pc_skip)
		else $error("skip request not turned into one pulse");
	AST_ACC_OR: assert property (
		(|pulse_q) && !acc_load && accumulator_clear_line_low
		|=> working_accumulator
		== ($past(working_accumulator) | ~$past(acc_in_bus_n)))
		else $error("accumulator input not inclusive OR");
	AST_ACC_CLR: assert property (
		(|pulse_q) && !acc_load && !accumulator_clear_line_low
		|=> working_accumulator == ~$past(acc_in_bus_n))
		else $error("accumulator clear with input wrong");

	COV_CYCLE: cover property ($rose(io_pause) ##[1:500] io_done);
	COV_ALL_PULSES: cover property (processor_pulse_third
		&& instr_q == 12'hfff);
	COV_SKIP: cover property (pc_skip);

endmodule : pio_io_pulse_gen

// ===== hdl/pio_slot_timer.sv
// Slot timer for the I/O pulse generator: counts cycles inside one slot.
// Assumes run is held for whole slots; dropping run returns to count zero.
`timescale 1ns/1ns
module pio_slot_timer #(
	parameter int SLOT_CLKS  = pio_pkg::SLOT_CLKS,
	parameter int PULSE_CLKS = pio_pkg::PULSE_CLKS
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// Control
	input  wire logic run,
	// Slot phases
	output logic      win,
	output logic      last,
	output logic      slot_end
);

	logic [pio_pkg::CNT_W-1:0] cnt_q;
	logic [pio_pkg::CNT_W-1:0] cnt_d;

	// Pulse plus its trailing strobe must fit inside a slot
	if (PULSE_CLKS < 1 || PULSE_CLKS + 2 > SLOT_CLKS
	    || SLOT_CLKS >= (1 << pio_pkg::CNT_W)) begin : g_chk
		$error("pio_slot_timer: slot or pulse length out of range");
	end

	always_comb begin
		if (!run || slot_end) begin
			cnt_d = '0;
		end else begin
			cnt_d = cnt_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign win      = run && (cnt_q < PULSE_CLKS[pio_pkg::CNT_W-1:0]);
	assign last     = run && (cnt_q == PULSE_CLKS[pio_pkg::CNT_W-1:0]);
	assign slot_end = run && (cnt_q == SLOT_CLKS[pio_pkg::CNT_W-1:0] - 1'b1);

endmodule : pio_slot_timer

// ===== inc/pio_pkg.sv
// Constants, field positions and states of the programmed-transfer I/O logic.
// Assumes a single 100 MHz clock shared with the processor timing chain.
package pio_pkg;

	// Timing figures as specified, and cycle counts derived from them
	localparam int CLK_PERIOD_NS = 10;
	localparam int IO_CYCLE_NS   = 4250;
	localparam int PULSE_NS      = 1000;
	// Whole cycle is a longest time, so it rounds down
	localparam int IO_CYCLE_CLKS = IO_CYCLE_NS / CLK_PERIOD_NS;
	localparam int SLOT_CLKS     = IO_CYCLE_CLKS / 3;
	localparam int PULSE_CLKS    = PULSE_NS / CLK_PERIOD_NS;
	localparam int CNT_W         = 9;

	// Instruction word; vector bit 0 is instruction bit 11
	localparam int          WORD_W    = 12;
	localparam int          OPC_MSB   = 11;
	localparam int          OPC_LSB   = 9;
	localparam logic [2:0]  OPC_IOT   = 3'h6;
	localparam int          SEL_MSB   = 8;
	localparam int          SEL_LSB   = 3;
	localparam int          SEL_W     = 6;
	localparam int          GATE_W    = 3;
	localparam logic [11:0] WORD_RST  = 12'h000;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_SLOT1 = 4'h2,
		ST_SLOT2 = 4'h4,
		ST_SLOT3 = 4'h8
	} pio_state_t;

endpackage : pio_pkg

// ===== sim/pio_dev_model.sv
// One selector channel plus a simple peripheral on the programmed I/O bus.
// Assumes pulled-up bus lines, so a released line reads as one.
`timescale 1ns/1ns
module pio_dev_model #(
	parameter logic [5:0] CODE = 6'h1c
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	// From the processor
	input  wire logic [2:0]  pulse,
	input  wire logic [5:0]  sel_t,
	input  wire logic [5:0]  sel_c,
	input  wire logic [11:0] bal,
	// Peripheral state set by the bench
	input  wire logic [1:0]  spare,
	input  wire logic        flag,
	input  wire logic [11:0] data,
	// To the processor
	output logic [11:0]      in_n,
	output logic             clr_n,
	output logic             skip_n,
	output logic [2:0]       cmd_n,
	output logic [11:0]      out_q
);
	logic [7:0] gate_in;
	logic [2:0] cmd;
	logic       load_q;
	assign gate_in = {spare, (sel_t & CODE) | (sel_c & ~CODE)};
	assign cmd_n   = ~({3{&gate_in}} & pulse);
	assign cmd     = ~cmd_n;
	assign skip_n  = ~(flag & cmd[0]);
	assign clr_n   = ~cmd[1];
	// Idle input lines sit at the pull-up level
	assign in_n    = cmd[2] ? ~data : 12'hfff;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			load_q <= 1'b0;
			out_q  <= 12'h000;
		end else begin
			load_q <= cmd[2];
			if (cmd[2] && !load_q)
				out_q <= bal;
		end
	end
endmodule : pio_dev_model

// ===== sim/programmed_io_pulse_bus_test.sv
// Self-checking bench for the processor end of the programmed I/O bus.
// Assumes one selector channel on the bus and shortened slot timing.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
	compares++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("CHECK FAILED %s expected %h seen %h", nm, (e), (g)); \
	end \
end
module programmed_io_pulse_bus_test;
	localparam int         SLOT = 8;
	localparam int         PW   = 3;
	localparam logic [5:0] CODE = 6'h1c;
	logic        ref_clk, rstn, vld, ftp, ld, flag, clr_n, skip_n;
	logic        pause, stb, done, skip;
	logic [11:0] mbr, ld_d, acc, bal, in_n, data, out_q;
	logic [2:0]  pulse, cmd_n;
	logic [5:0]  sel_t, sel_c;
	logic [1:0]  spare;
	int          seed = 12;
	int          miscompares = 0;
	int          compares = 0;
	int          cyc = 0;
	int          scnt = 0;
	int          pcnt [3];

	pio_io_pulse_gen #(.SLOT_CLKS(SLOT), .PULSE_CLKS(PW)) dut (
		.ref_clk(ref_clk), .rstn(rstn), .memory_buffer_register(mbr),
		.instr_valid(vld), .fourth_timing_pulse(ftp), .acc_load(ld),
		.acc_load_data(ld_d), .io_pause(pause), .io_strobe(stb),
		.io_done(done), .pc_skip(skip), .working_accumulator(acc),
		.processor_pulse_first(pulse[0]), .processor_pulse_second(pulse[1]),
		.processor_pulse_third(pulse[2]), .select_code_true(sel_t),
		.select_code_comp(sel_c), .buffered_accumulator_lines(bal),
		.acc_in_bus_n(in_n), .accumulator_clear_line_low(clr_n),
		.skip_bus_n(skip_n));
	pio_dev_model #(.CODE(CODE)) dev (
		.ref_clk(ref_clk), .rstn(rstn), .pulse(pulse), .sel_t(sel_t),
		.sel_c(sel_c), .bal(bal), .spare(spare), .flag(flag), .data(data),
		.in_n(in_n), .clr_n(clr_n), .skip_n(skip_n), .cmd_n(cmd_n),
		.out_q(out_q));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic results();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (compares > 0 && miscompares == 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	always @(posedge ref_clk) begin
		cyc++;
		scnt += stb;
		for (int i = 0; i < 3; i++)
			pcnt[i] += pulse[i];
		if (cyc == 5000) begin
			miscompares++;
			results();
		end
	end

	function automatic logic [11:0] exp_acc(input logic [11:0] a, w, d,
			input logic m);
		if (m && w[1])
			a = 12'h000;
		if (m && w[2])
			a = a | d;
		return a;
	endfunction : exp_acc

	task automatic go(input logic [11:0] w, input logic v);
		logic [11:0] a0, d, lat;
		logic [1:0]  sp;
		logic        f, m;
		int          n;
		a0 = 12'($random(seed));
		d = 12'($random(seed));
		f = 1'($random(seed));
		sp = ($random(seed) % 4 == 0) ? 2'($random(seed)) : 2'b11;
		m = v && w[11:9] == 3'h6 && w[8:3] == CODE && sp == 2'b11;
		lat = out_q;
		@(posedge ref_clk);
		ld <= 1'b1;
		ld_d <= a0;
		data <= d;
		flag <= f;
		spare <= sp;
		@(posedge ref_clk);
		ld <= 1'b0;
		mbr <= w;
		vld <= v;
		ftp <= 1'b1;
		@(posedge ref_clk);
		ftp <= 1'b0;
		#1;
		scnt = 0;
		pcnt = '{0, 0, 0};
		`CHK("pause", v && w[11:9] == 3'h6, pause)
		if (!(v && w[11:9] == 3'h6)) begin
			`CHK("idle_acc", a0, acc)
			return;
		end
		`CHK("sel_t", w[8:3], sel_t)
		`CHK("sel_c", ~w[8:3], sel_c)
		n = 0;
		while (done !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		`CHK("cycle", 3 * SLOT, n)
		`CHK("pause_end", 1'b0, pause)
		`CHK("strobes", 3, scnt)
		for (int i = 0; i < 3; i++)
			`CHK("pulse", w[i] ? PW : 0, pcnt[i])
		`CHK("acc", exp_acc(a0, w, d, m), acc)
		`CHK("bal", exp_acc(a0, w, d, m), bal)
		if (m && w[2])
			lat = w[1] ? 12'h000 : a0;
		`CHK("latched", lat, out_q)
		`CHK("skip", m && w[0] && f, skip)
		@(posedge ref_clk);
		#1;
		`CHK("skip_end", 1'b0, skip)
	endtask : go

	initial begin
		rstn = 1'b0;
		vld = 1'b0;
		ftp = 1'b0;
		ld = 1'b0;
		ld_d = 12'h000;
		mbr = 12'h000;
		data = 12'h000;
		flag = 1'b0;
		spare = 2'b11;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		#1;
		`CHK("rst_comp", 6'h3f, sel_c)
		`CHK("rst_pause", 1'b0, pause)
		`CHK("rst_acc", 12'h000, acc)
		for (int i = 0; i < 24; i++)
			go({3'h6, (i % 3 == 2) ? 6'($random(seed)) : CODE, 3'(i)}, 1'b1);
		// Every opcode once; the transfer opcode without a valid word
		for (int i = 0; i < 8; i++)
			go({3'(i), CODE, 3'h7}, i != 6);
		results();
	end
endmodule : programmed_io_pulse_bus_test
